// File: src/rsp_slave.v
// Controlled-station protocol engine: commands, events, polls, framing
`include "rsp_defs.vh"

module rsp_slave #(
  parameter QDEPTH = 8,
  parameter QAW = 3,
  parameter NIND = 11,
  parameter [7:0] MAX_APDU = `RSP_MAX_APDU
) (
  input wire clock, // System clock, 40 MHz
  input wire srst, // Synchronous reset, active high
  input wire ce, // Clock enable, freezes all state when low
  input wire [7:0] station_addr, // Own link address, 1..254
  input wire [1:0] baud_sel, // 0: 9600, 1: 19200, 2: 57600
  output wire [12:0] baud_div, // Clock cycles per bit for the UART
  input wire cmd_valid, // Parsed master frame present
  output wire cmd_ready, // Engine takes the frame
  input wire [2:0] cmd_link_func, // Link function code
  input wire [7:0] cmd_addr, // Link address of the frame
  input wire cmd_fcb, // Frame count bit of the frame
  input wire [7:0] cmd_type, // Unit type of user data
  input wire [7:0] cmd_fun, // Function number of user data
  input wire [7:0] cmd_inf, // Information number of user data
  input wire [1:0] cmd_dco, // Double command state
  input wire [10:0] ind_pins, // Indication inputs, asynchronous
  input wire fault_strobe, // Fault currents valid, one cycle
  input wire [15:0] fault_hv, // HV fault current
  input wire [15:0] fault_lv, // LV fault current
  input wire [15:0] fault_diff, // Differential current
  input wire [15:0] meas_hv, // HV current, thousandths of rated
  input wire [15:0] meas_lv, // LV current, thousandths of rated
  output wire led_reset_pulse, // Command effect, one cycle
  output wire fcb_state, // Internal frame count bit
  output wire [7:0] tx_octet, // Response octet
  output wire tx_last, // Last octet of a frame
  output wire tx_valid, // Octet present
  input wire tx_ready // Transmitter takes the octet
);

  localparam [1:0] K_ACK = 2'h0;
  localparam [1:0] K_EVT = 2'h1;
  localparam [1:0] K_MEAS = 2'h2;
  localparam [1:0] CS_IDLE = 2'h0;
  localparam [1:0] CS_POS = 2'h1;
  localparam [1:0] CS_CHG = 2'h2;
  localparam [1:0] CS_NEG = 2'h3;
  localparam integer D96 = `RSP_CLK_HZ / `RSP_BAUD_9600;
  localparam integer D192 = `RSP_CLK_HZ / `RSP_BAUD_19200;
  localparam integer D576 = `RSP_CLK_HZ / `RSP_BAUD_57600;

  // Indication table: {in scan, double transition, information number}
  function [9:0] ind_info;
    input [3:0] i;
    begin
      case (i)
        4'd0: ind_info = {2'b00, 8'h12};
        4'd1: ind_info = {2'b00, 8'h16};
        4'd2: ind_info = {2'b11, 8'h1b};
        4'd3: ind_info = {2'b11, 8'h1c};
        4'd4: ind_info = {2'b11, 8'h1d};
        4'd5: ind_info = {2'b11, 8'h1e};
        4'd6: ind_info = {2'b11, 8'h24};
        4'd7: ind_info = {2'b11, 8'h26};
        4'd8: ind_info = {2'b11, 8'h7c};
        4'd9: ind_info = {2'b11, 8'h7d};
        default: ind_info = {2'b00, 8'h28};
      endcase
    end
  endfunction

  // Scaled measurand word: value in bits 15..3, overflow in bit 0
  function [15:0] meas_word;
    input [15:0] raw;
    reg [31:0] prod;
    reg [17:0] val;
    begin
      prod = raw * `RSP_SCALE_MUL;
      val = prod[31:`RSP_SCALE_SHIFT];
      if (val >= `RSP_MEAS_FULL)
        meas_word = {13'h0fff, 3'h1};
      else
        meas_word = {val[12:0], 3'h0};
    end
  endfunction

  // Queue entry: {type, cause, function, information, data}
  function [47:0] entry;
    input [7:0] typ;
    input [7:0] cot;
    input [7:0] fun;
    input [7:0] inf;
    input [15:0] dat;
    begin
      entry = {typ, cot, fun, inf, dat};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State
  reg [10:0] ind_s1_q, ind_s2_q, ind_prev_q, pend_q;
  reg [47:0] q_mem [0:QDEPTH-1];
  reg [QAW-1:0] q_wp_q, q_rp_q;
  reg [QAW:0] q_cnt_q;
  reg [1:0] cs_q;
  reg ack_pend_q;
  reg [7:0] cfun_q, cinf_q;
  reg [1:0] cdco_q;
  reg gi_act_q;
  reg [3:0] gi_idx_q;
  reg [1:0] flt_q;
  reg [15:0] fhv_q, flv_q, fdf_q;
  reg busy_q;
  reg [1:0] kind_q;
  reg [3:0] idx_q, len_q;
  reg [47:0] frm_q;
  reg [15:0] mhv_q, mlv_q;
  reg [7:0] addr_q;
  reg fcb_q, led_q;
  reg [12:0] baud_q;
  reg [8:0] buf_q [0:1];
  reg buf_wp_q, buf_rp_q;
  reg [1:0] buf_cnt_q;

  ////////////////////////////////////////////////////////////////////////
  // Edge detection and indication tables
  reg [10:0] dt_mask, gi_mask, edge_set, edge_clr;
  reg [9:0] info;
  integer k;
  always @* begin
    for (k = 0; k < NIND; k = k + 1) begin
      info = ind_info(k[3:0]);
      gi_mask[k] = info[9];
      dt_mask[k] = info[8];
    end
    edge_set = (ind_s2_q & ~ind_prev_q) | (~ind_s2_q & ind_prev_q & dt_mask);
  end

  // Lowest pending edge wins; one event per cycle
  reg edge_any;
  reg [3:0] edge_idx;
  integer j;
  // Table lookups for the scan and the edge entries
  wire [9:0] gi_info = ind_info(gi_idx_q);
  wire [9:0] ev_info = ind_info(edge_idx);
  always @* begin
    edge_any = 1'b0;
    edge_idx = 4'h0;
    for (j = NIND - 1; j >= 0; j = j - 1) begin
      if (pend_q[j]) begin
        edge_any = 1'b1;
        edge_idx = j[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command decode
  wire q_full = (q_cnt_q == QDEPTH);
  wire q_empty = (q_cnt_q == {(QAW+1){1'b0}});
  wire acc = cmd_valid & cmd_ready;
  wire bcast = (cmd_addr == `RSP_ADDR_BCAST);
  wire own = (cmd_addr == station_addr) &&
    (station_addr != `RSP_ADDR_NONE) && (station_addr != `RSP_ADDR_BCAST);
  wire hit = own | bcast;
  wire is_cu = (cmd_link_func == `RSP_LF_RESET_CU);
  wire is_rfcb = (cmd_link_func == `RSP_LF_RESET_FCB);
  wire is_ud = (cmd_link_func == `RSP_LF_USER_DATA);
  wire is_p1 = (cmd_link_func == `RSP_LF_POLL_C1);
  wire is_p2 = (cmd_link_func == `RSP_LF_POLL_C2);
  wire flush = acc & hit & is_cu;
  wire ud = acc & hit & is_ud;
  wire gi_start = ud & (cmd_type == `RSP_TYP_GI_START);
  wire gc = ud & (cmd_type == `RSP_TYP_GEN_CMD);
  wire gc_take = gc & ~ack_pend_q;
  wire gc_ok = (cmd_fun == `RSP_FUN_MAIN) &&
    (cmd_inf == `RSP_INF_LED_RESET) && (cmd_dco == `RSP_DCO_ON);
  wire poll1 = acc & own & is_p1;
  wire poll2 = acc & own & is_p2;
  wire pop = poll1 & ~q_empty;
  wire [47:0] q_head = q_mem[q_rp_q];
  wire head_ack = (q_head[39:32] == `RSP_COT_CMD_ACK) ||
    (q_head[39:32] == `RSP_COT_CMD_NAK);

  ////////////////////////////////////////////////////////////////////////
  // Enqueue arbitration: command, scan, fault, spontaneous edges
  reg enq;
  reg [47:0] enq_d;
  reg [2:0] src;
  always @* begin
    enq = 1'b0;
    enq_d = 48'h0;
    src = 3'h0;
    if (!q_full && !flush) begin
      if (cs_q == CS_POS) begin
        enq = 1'b1;
        enq_d = entry(`RSP_TYP_TTM, `RSP_COT_CMD_ACK, cfun_q, cinf_q,
          {14'h0, cdco_q});
        src = 3'h1;
      end else if (cs_q == CS_NEG) begin
        enq = 1'b1;
        enq_d = entry(`RSP_TYP_TTM, `RSP_COT_CMD_NAK, cfun_q, cinf_q,
          {14'h0, cdco_q});
        src = 3'h1;
      end else if (cs_q == CS_CHG) begin
        enq = 1'b1;
        enq_d = entry(`RSP_TYP_TTM, `RSP_COT_SPONT, cfun_q, cinf_q,
          16'h0002);
        src = 3'h1;
      end else if (gi_act_q) begin
        src = 3'h2;
        if (gi_idx_q == NIND[3:0]) begin
          enq = 1'b1;
          enq_d = entry(`RSP_TYP_GI_END, `RSP_COT_GI_END, `RSP_FUN_GLB,
            `RSP_INF_GI_END, 16'h0);
        end else if (gi_mask[gi_idx_q]) begin
          enq = 1'b1;
          enq_d = entry(`RSP_TYP_TTM, `RSP_COT_GI, `RSP_FUN_MAIN,
            gi_info[7:0],
            ind_s2_q[gi_idx_q] ? 16'h0002 : 16'h0001);
        end
      end else if (flt_q != 2'h0) begin
        enq = 1'b1;
        src = 3'h3;
        case (flt_q)
          2'h1: enq_d = entry(`RSP_TYP_MEAS_TT, `RSP_COT_SPONT,
            `RSP_FUN_MAIN, `RSP_INF_FAULT_HV, fhv_q);
          2'h2: enq_d = entry(`RSP_TYP_MEAS_TT, `RSP_COT_SPONT,
            `RSP_FUN_MAIN, `RSP_INF_FAULT_LV, flv_q);
          default: enq_d = entry(`RSP_TYP_MEAS_TT, `RSP_COT_SPONT,
            `RSP_FUN_MAIN, `RSP_INF_FAULT_DIFF, fdf_q);
        endcase
      end else if (edge_any) begin
        enq = 1'b1;
        src = 3'h4;
        enq_d = entry(`RSP_TYP_TTM, `RSP_COT_SPONT, `RSP_FUN_MAIN,
          ev_info[7:0],
          ind_s2_q[edge_idx] ? 16'h0002 : 16'h0001);
      end
    end
    edge_clr = 11'h0;
    if (src == 3'h4)
      edge_clr[edge_idx] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame serializer, octets pushed into the two-entry buffer
  reg [7:0] oct;
  always @* begin
    oct = `RSP_ACK_CHAR;
    if (kind_q == K_EVT) begin
      case (idx_q)
        4'd0: oct = frm_q[47:40];
        4'd1: oct = `RSP_VSQ_ONE;
        4'd2: oct = frm_q[39:32];
        4'd3: oct = addr_q;
        4'd4: oct = frm_q[31:24];
        4'd5: oct = frm_q[23:16];
        4'd6: oct = frm_q[7:0];
        default: oct = frm_q[15:8];
      endcase
    end else if (kind_q == K_MEAS) begin
      case (idx_q)
        4'd0: oct = `RSP_TYP_MEAS2;
        4'd1: oct = `RSP_VSQ_MEAS;
        4'd2: oct = `RSP_COT_CYCLIC;
        4'd3: oct = addr_q;
        4'd4: oct = `RSP_FUN_MAIN;
        4'd5: oct = `RSP_INF_MEAS;
        4'd6: oct = mhv_q[7:0];
        4'd7: oct = mhv_q[15:8];
        4'd8: oct = mlv_q[7:0];
        default: oct = mlv_q[15:8];
      endcase
    end
  end

  // Buffer handshake; ready stalls the serializer and, through busy, the link
  wire buf_in_rdy = (buf_cnt_q != 2'h2);
  wire buf_push = busy_q & buf_in_rdy;
  wire buf_pop = ce & tx_ready & (buf_cnt_q != 2'h0);
  wire oct_last = (idx_q == len_q - 4'h1);
  // Clamp to the configured unit size; all frames here stay far below it
  wire [3:0] evt_len = (MAX_APDU < {4'h0, `RSP_LEN_EVT}) ?
    MAX_APDU[3:0] : `RSP_LEN_EVT;

  ////////////////////////////////////////////////////////////////////////
  // Sequential state
  always @(posedge clock) begin
    if (srst) begin
      ind_s1_q <= 11'h0;
      ind_s2_q <= 11'h0;
      ind_prev_q <= 11'h0;
      pend_q <= 11'h0;
      q_wp_q <= {QAW{1'b0}};
      q_rp_q <= {QAW{1'b0}};
      q_cnt_q <= {(QAW+1){1'b0}};
      cs_q <= CS_IDLE;
      ack_pend_q <= 1'b0;
      cfun_q <= 8'h00;
      cinf_q <= 8'h00;
      cdco_q <= 2'h0;
      gi_act_q <= 1'b0;
      gi_idx_q <= 4'h0;
      flt_q <= 2'h0;
      fhv_q <= 16'h0000;
      flv_q <= 16'h0000;
      fdf_q <= 16'h0000;
      busy_q <= 1'b0;
      kind_q <= K_ACK;
      idx_q <= 4'h0;
      len_q <= 4'h1;
      frm_q <= 48'h0;
      mhv_q <= 16'h0000;
      mlv_q <= 16'h0000;
      addr_q <= 8'h00;
      fcb_q <= 1'b0;
      led_q <= 1'b0;
      baud_q <= D96[12:0];
      buf_wp_q <= 1'b0;
      buf_rp_q <= 1'b0;
      buf_cnt_q <= 2'h0;
    end else if (ce) begin
      // Two-flop synchroniser; only the second stage feeds logic
      ind_s1_q <= ind_pins;
      ind_s2_q <= ind_s1_q;
      ind_prev_q <= ind_s2_q;
      pend_q <= (pend_q & ~edge_clr) | edge_set; // set wins over clear
      led_q <= 1'b0;
      // Unknown selections keep the last valid rate
      case (baud_sel)
        2'h0: baud_q <= D96[12:0];
        2'h1: baud_q <= D192[12:0];
        2'h2: baud_q <= D576[12:0];
        default: baud_q <= baud_q;
      endcase
      // Queue storage
      if (enq)
        q_mem[q_wp_q] <= enq_d;
      if (flush) begin
        q_wp_q <= {QAW{1'b0}};
        q_rp_q <= {QAW{1'b0}};
        q_cnt_q <= {(QAW+1){1'b0}};
      end else begin
        if (enq)
          q_wp_q <= q_wp_q + 1'b1;
        if (pop)
          q_rp_q <= q_rp_q + 1'b1;
        if (enq && !pop)
          q_cnt_q <= q_cnt_q + 1'b1;
        else if (pop && !enq)
          q_cnt_q <= q_cnt_q - 1'b1;
      end
      // Command stages and acknowledgement lock
      if (src == 3'h1)
        cs_q <= (cs_q == CS_POS) ? CS_CHG : CS_IDLE;
      if (pop && head_ack)
        ack_pend_q <= 1'b0;
      if (flush) begin
        cs_q <= CS_IDLE;
        ack_pend_q <= 1'b0;
        gi_act_q <= 1'b0;
      end else if (gc_take) begin
        ack_pend_q <= 1'b1;
        cfun_q <= cmd_fun;
        cinf_q <= cmd_inf;
        cdco_q <= cmd_dco;
        cs_q <= gc_ok ? CS_POS : CS_NEG;
        led_q <= gc_ok;
      end
      // Interrogation scan; a new start restarts it
      if (gi_start) begin
        gi_act_q <= 1'b1;
        gi_idx_q <= 4'h0;
      end else if (src == 3'h2) begin
        if (gi_idx_q == NIND[3:0])
          gi_act_q <= 1'b0;
        gi_idx_q <= gi_idx_q + 4'h1;
      end
      // Fault capture; a strobe during an unsent set is dropped
      if (fault_strobe && flt_q == 2'h0 && !flush) begin
        fhv_q <= fault_hv;
        flv_q <= fault_lv;
        fdf_q <= fault_diff;
        flt_q <= 2'h1;
      end else if (src == 3'h3) begin
        flt_q <= (flt_q == 2'h3) ? 2'h0 : flt_q + 2'h1;
      end
      // Frame count bit tracking
      if (acc && hit && (is_cu || is_rfcb))
        fcb_q <= 1'b0;
      else if (acc && own && (is_p1 || is_p2 || is_ud))
        fcb_q <= cmd_fcb;
      // Response start: broadcasts get no reply
      if (acc && own && !is_p1 && !is_p2 && (is_cu || is_rfcb || is_ud)) begin
        busy_q <= 1'b1;
        kind_q <= K_ACK;
        len_q <= `RSP_LEN_ACK;
        idx_q <= 4'h0;
      end else if (poll1) begin
        busy_q <= 1'b1;
        kind_q <= q_empty ? K_ACK : K_EVT;
        len_q <= q_empty ? `RSP_LEN_ACK : evt_len;
        frm_q <= q_head;
        addr_q <= station_addr;
        idx_q <= 4'h0;
      end else if (poll2) begin
        busy_q <= 1'b1;
        kind_q <= K_MEAS;
        len_q <= `RSP_LEN_MEAS;
        mhv_q <= meas_word(meas_hv);
        mlv_q <= meas_word(meas_lv);
        addr_q <= station_addr;
        idx_q <= 4'h0;
      end else if (buf_push) begin
        idx_q <= idx_q + 4'h1;
        if (oct_last)
          busy_q <= 1'b0;
      end
      // Two-entry buffer keeps octets flowing back to back
      if (buf_push) begin
        buf_q[buf_wp_q] <= {oct_last, oct};
        buf_wp_q <= ~buf_wp_q;
      end
      if (buf_pop)
        buf_rp_q <= ~buf_rp_q;
      if (buf_push && !buf_pop)
        buf_cnt_q <= buf_cnt_q + 2'h1;
      else if (buf_pop && !buf_push)
        buf_cnt_q <= buf_cnt_q - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign cmd_ready = ce & ~srst & ~busy_q;
  assign tx_valid = ce & (buf_cnt_q != 2'h0);
  assign tx_octet = buf_q[buf_rp_q][7:0];
  assign tx_last = buf_q[buf_rp_q][8];
  assign baud_div = baud_q;
  assign fcb_state = fcb_q;
  assign led_reset_pulse = led_q;

endmodule // rsp_slave

// File: src/rsp_defs.vh
// Shared constants for the relay SCADA slave protocol engine
`ifndef RSP_DEFS_VH
`define RSP_DEFS_VH

// Link function codes delivered by the frame parser
`define RSP_LF_RESET_CU 3'h0
`define RSP_LF_RESET_FCB 3'h1
`define RSP_LF_USER_DATA 3'h2
`define RSP_LF_POLL_C1 3'h3
`define RSP_LF_POLL_C2 3'h4

// Application unit types
`define RSP_TYP_TTM 8'h01
`define RSP_TYP_MEAS_TT 8'h04
`define RSP_TYP_GI_START 8'h07
`define RSP_TYP_GI_END 8'h08
`define RSP_TYP_MEAS2 8'h09
`define RSP_TYP_GEN_CMD 8'h14

// Causes of transmission
`define RSP_COT_SPONT 8'h01
`define RSP_COT_CYCLIC 8'h02
`define RSP_COT_GI 8'h09
`define RSP_COT_GI_END 8'h0a
`define RSP_COT_CMD_ACK 8'h14
`define RSP_COT_CMD_NAK 8'h15

// Function and information numbers
`define RSP_FUN_MAIN 8'hb0
`define RSP_FUN_GLB 8'hff
`define RSP_INF_GI_END 8'h00
`define RSP_INF_LED_RESET 8'h13
`define RSP_INF_MEAS 8'h94
`define RSP_INF_FAULT_HV 8'h8d
`define RSP_INF_FAULT_LV 8'h8e
`define RSP_INF_FAULT_DIFF 8'h8f

// Frame constants
`define RSP_ACK_CHAR 8'he5
`define RSP_VSQ_ONE 8'h81
`define RSP_VSQ_MEAS 8'h02
`define RSP_ADDR_BCAST 8'hff
`define RSP_ADDR_NONE 8'h00
`define RSP_MAX_APDU 8'hfd
`define RSP_LEN_ACK 4'h1
`define RSP_LEN_EVT 4'h8
`define RSP_LEN_MEAS 4'ha
`define RSP_DCO_ON 2'h2

// Bit rates and clock
`define RSP_CLK_HZ 40000000
`define RSP_BAUD_9600 9600
`define RSP_BAUD_19200 19200
`define RSP_BAUD_57600 57600

// Measurand scaling: input in thousandths of rated, 2400 maps to 4096
`define RSP_MEAS_FULL 4096
`define RSP_SCALE_MUL 16'h6d3b
`define RSP_SCALE_SHIFT 14

`endif

// File: verif/rsp_slave_sva.sv
// Port checker for the relay SCADA slave engine
module rsp_slave_sva (
  input wire clock, // Clock
  input wire srst, // Reset
  input wire ce, // Enable
  input wire [7:0] station_addr, // Own address
  input wire [1:0] baud_sel, // Rate select
  input wire [12:0] baud_div, // Bit period
  input wire cmd_valid, // Frame offered
  input wire cmd_ready, // Frame taken
  input wire [2:0] cmd_link_func, // Link function
  input wire [7:0] cmd_addr, // Frame address
  input wire led_reset_pulse, // Command effect
  input wire fcb_state, // Frame count bit
  input wire [7:0] tx_octet, // Octet out
  input wire tx_last, // Frame end
  input wire tx_valid, // Octet present
  input wire tx_ready // Octet taken
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  //////////////////////////////////////////////////////////////////////
  // Own-address accept, the start of every reply
  sequence s_take;
    cmd_valid && cmd_ready && cmd_addr == station_addr;
  endsequence
  // Head of the class 2 measurand frame
  sequence s_meas;
    tx_octet == 8'h09 ##1 tx_octet == 8'h02 ##1 tx_octet == 8'h02
    ##1 tx_octet == station_addr ##1 tx_octet == 8'hb0
    ##1 tx_octet == 8'h94;
  endsequence
  property p_baud;
    ce && baud_sel != 2'h3 |=> baud_div == ($past(baud_sel) == 2'h0 ?
      13'h1046 : $past(baud_sel) == 2'h1 ? 13'h823 : 13'h2b6);
  endproperty
  a_baud: assert property (p_baud) else $error("bit period wrong");
  property p_ack;
    s_take ##0 (cmd_link_func <= 3'h2 && !tx_valid)
      |-> ##2 tx_valid && tx_last && tx_octet == 8'he5;
  endproperty
  a_ack: assert property (p_ack) else $error("link ack missing");
  property p_busy;
    s_take ##0 cmd_link_func <= 3'h4 |=> !cmd_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("second frame taken");
  property p_meas;
    s_take ##0 (cmd_link_func == 3'h4 && !tx_valid) |-> ##2 s_meas;
  endproperty
  a_meas: assert property (p_meas) else $error("measurand head wrong");
  property p_bcast;
    cmd_valid && cmd_ready && cmd_addr == 8'hff && !tx_valid
      |=> (cmd_ready && !tx_valid) [*3];
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast answered");
  property p_fcb;
    s_take ##0 cmd_link_func == 3'h1 |=> !fcb_state;
  endproperty
  a_fcb: assert property (p_fcb) else $error("count bit not cleared");
  property p_hold;
    tx_valid && !tx_ready ##1 ce
      |-> tx_valid && $stable(tx_octet) && $stable(tx_last);
  endproperty
  a_hold: assert property (p_hold) else $error("octet lost in stall");
  property p_led;
    led_reset_pulse |=> !led_reset_pulse;
  endproperty
  a_led: assert property (p_led) else $error("command pulse too long");
endmodule // rsp_slave_sva

// Attach to every engine instance
bind rsp_slave rsp_slave_sva u_sva (.*);

// File: verif/rsp_master_model.sv
// Control station model: issues link frames and sinks reply octets
module rsp_master_model (
  input wire clock, // Clock
  input wire stall, // Hold off all octets
  input wire slow, // Take an octet every other cycle
  input wire ce, // Engine enable
  input wire cmd_ready, // Engine takes frame
  input wire [7:0] tx_octet, // Reply octet
  input wire tx_last, // Reply frame end
  input wire tx_valid, // Reply octet present
  output logic cmd_valid = 1'b0, // Frame offered
  output logic [2:0] cmd_link_func = 3'h0, // Link function
  output logic [7:0] cmd_addr = 8'h00, // Frame address
  output logic cmd_fcb = 1'b0, // Frame count bit
  output logic [7:0] cmd_type = 8'h00, // Unit type
  output logic [7:0] cmd_fun = 8'h00, // Function number
  output logic [7:0] cmd_inf = 8'h00, // Information number
  output logic [1:0] cmd_dco = 2'h0, // Command state
  output logic tx_ready = 1'b1 // Takes octet
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] rxq[$]; // Received octets, frame end in bit 8
  //////////////////////////////////////////////////////////////////////
  // One frame at a time; a class 1 poll is the slave's only grant to send events
  task automatic send(input logic [2:0] f, input logic [7:0] a, t, fu,
                      inf, input logic [1:0] d, input logic b);
    int n;
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_link_func <= f;
    cmd_addr <= a;
    cmd_type <= t;
    cmd_fun <= fu;
    cmd_inf <= inf;
    cmd_dco <= d;
    cmd_fcb <= b;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (!cmd_ready && n < 300);
    cmd_valid <= 1'b0;
    // Released fields must not keep looking valid
    cmd_addr <= ~a;
    cmd_type <= ~t;
    cmd_fun <= ~fu;
    cmd_inf <= ~inf;
  endtask
  // Octet sink; slow mode drops ready every other cycle
  always @(posedge clock) begin
    if (tx_valid && tx_ready && ce)
      rxq.push_back({tx_last, tx_octet});
    tx_ready <= !stall && !(slow && tx_ready);
  end
endmodule // rsp_master_model

// File: verif/testbench.sv
// Self-checking bench for the relay SCADA slave engine
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic stall = 1'b0;
  logic slow = 1'b0;
  logic [7:0] station_addr = 8'h05;
  logic [1:0] baud_sel = 2'h0;
  logic [10:0] ind_pins = 11'h000;
  logic fault_strobe = 1'b0;
  logic [15:0] fault_hv = 16'h0, fault_lv = 16'h0, fault_diff = 16'h0;
  logic [15:0] meas_hv = 16'h0, meas_lv = 16'h0;
  wire [12:0] baud_div;
  wire cmd_valid, cmd_ready, cmd_fcb, led_reset_pulse, fcb_state;
  wire tx_last, tx_valid, tx_ready;
  wire [7:0] cmd_addr, cmd_type, cmd_fun, cmd_inf, tx_octet;
  wire [2:0] cmd_link_func;
  wire [1:0] cmd_dco;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_led = 0;
  //////////////////////////////////////////////////////////////////////
  // Clock and command execution count
  always #12.5 clock = ~clock;
  always @(posedge clock) if (led_reset_pulse === 1'b1) n_led++;
  rsp_slave u_dut (.*);
  rsp_master_model u_master (.*);
  //////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input string what, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Wait for a whole reply; trailing octets of unknown content skipped
  task automatic frame(input logic [7:0] e[$], input int skip);
    logic [8:0] got;
    int n;
    n = 0;
    while (u_master.rxq.size() < e.size() && n < 400) begin
      @(posedge clock);
      n++;
    end
    foreach (e[i]) begin
      got = 'x;
      if (u_master.rxq.size() > 0)
        got = u_master.rxq.pop_front();
      if (i < e.size() - skip)
        check("octet", got[7:0], e[i]);
      check("frame end", got[8], i == e.size() - 1);
    end
  endtask
  // Frame answered by the single link acknowledge octet
  task automatic ack(input logic [2:0] f, input logic [7:0] a, t, fu, inf);
    u_master.send(f, a, t, fu, inf, 2'h2, f != 3'h1);
    frame('{8'he5}, 0);
  endtask
  // Class 1 poll expecting one event frame
  task automatic poll_evt(input logic [7:0] typ, cot, fu, inf, lo, hi,
                          input int skip);
    u_master.send(3'h3, station_addr, 8'h00, 8'h00, 8'h00, 2'h0, 1'b1);
    frame('{typ, 8'h81, cot, station_addr, fu, inf, lo, hi}, skip);
  endtask
  // Fault capture pulse, then time to queue the triple
  task automatic strobe(input logic [15:0] h, l, d);
    fault_hv <= h;
    fault_lv <= l;
    fault_diff <= d;
    fault_strobe <= 1'b1;
    @(posedge clock);
    fault_strobe <= 1'b0;
    repeat (10) @(posedge clock);
  endtask
  //////////////////////////////////////////////////////////////////////
  // Rate select; code 3 keeps the last period
  task automatic t_baud;
    logic [12:0] tbl[3] = '{13'h1046, 13'h823, 13'h2b6};
    for (int i = 0; i < 4; i++) begin
      baud_sel <= i[1:0];
      repeat (3) @(posedge clock);
      check("baud_div", baud_div, tbl[i < 3 ? i : 2]);
    end
    // Enable low must freeze the period
    ce <= 1'b0;
    baud_sel <= 2'h0;
    repeat (3) @(posedge clock);
    check("frozen", baud_div, 13'h2b6);
    ce <= 1'b1;
    $display("test baud done");
  endtask
  // Link replies, broadcast, foreign and top address, empty poll
  task automatic t_link;
    ack(3'h0, station_addr, 8'h00, 8'h00, 8'h00);
    ack(3'h2, station_addr, 8'h05, 8'h00, 8'h00);
    u_master.send(3'h0, 8'hff, 8'h00, 8'h00, 8'h00, 2'h0, 1'b0);
    u_master.send(3'h3, 8'h06, 8'h00, 8'h00, 8'h00, 2'h0, 1'b0);
    repeat (8) @(posedge clock);
    check("silent", u_master.rxq.size(), 0);
    station_addr <= 8'hfe;
    ack(3'h1, 8'hfe, 8'h00, 8'h00, 8'h00);
    station_addr <= 8'h05;
    ack(3'h3, 8'h05, 8'h00, 8'h00, 8'h00);
    $display("test link done");
  endtask
  // Command, refused repeat, state change, negative answer
  task automatic t_cmd;
    ack(3'h2, station_addr, 8'h14, 8'hb0, 8'h13);
    ack(3'h2, station_addr, 8'h14, 8'hb0, 8'h13);
    repeat (10) @(posedge clock);
    check("executions", n_led, 1);
    poll_evt(8'h01, 8'h14, 8'hb0, 8'h13, 8'h02, 8'h00, 0);
    poll_evt(8'h01, 8'h01, 8'hb0, 8'h13, 8'h02, 8'h00, 0);
    ack(3'h3, station_addr, 8'h00, 8'h00, 8'h00);
    ack(3'h2, station_addr, 8'h14, 8'hb0, 8'h20);
    poll_evt(8'h01, 8'h15, 8'hb0, 8'h20, 8'h02, 8'h00, 0);
    $display("test command done");
  endtask
  // Spontaneous edges: single and double transition inputs
  task automatic t_events;
    ind_pins <= 11'h202;
    repeat (10) @(posedge clock);
    poll_evt(8'h01, 8'h01, 8'hb0, 8'h16, 8'h02, 8'h00, 0);
    poll_evt(8'h01, 8'h01, 8'hb0, 8'h7d, 8'h02, 8'h00, 0);
    ind_pins <= 11'h000;
    repeat (10) @(posedge clock);
    poll_evt(8'h01, 8'h01, 8'hb0, 8'h7d, 8'h01, 8'h00, 0);
    ack(3'h3, station_addr, 8'h00, 8'h00, 8'h00);
    $display("test events done");
  endtask
  // Interrogation scan drained by a slow receiver
  task automatic t_gi;
    logic [7:0] inf[8] = '{8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h24, 8'h26,
                           8'h7c, 8'h7d};
    ind_pins <= 11'h200;
    repeat (10) @(posedge clock);
    poll_evt(8'h01, 8'h01, 8'hb0, 8'h7d, 8'h02, 8'h00, 0);
    ack(3'h2, station_addr, 8'h07, 8'hff, 8'h00);
    slow <= 1'b1;
    for (int i = 0; i < 8; i++)
      poll_evt(8'h01, 8'h09, 8'hb0, inf[i], i == 7 ? 8'h02 : 8'h01,
               8'h00, 0);
    poll_evt(8'h08, 8'h0a, 8'hff, 8'h00, 8'h00, 8'h00, 2);
    slow <= 1'b0;
    ack(3'h3, station_addr, 8'h00, 8'h00, 8'h00);
    $display("test interrogation done");
  endtask
  // Fault triple, both resets, receiver stalled with buffer full
  task automatic t_fault;
    strobe(16'h1234, 16'h5678, 16'h9abc);
    poll_evt(8'h04, 8'h01, 8'hb0, 8'h8d, 8'h34, 8'h12, 0);
    check("fcb", fcb_state, 1);
    ack(3'h1, station_addr, 8'h00, 8'h00, 8'h00);
    check("fcb", fcb_state, 0);
    poll_evt(8'h04, 8'h01, 8'hb0, 8'h8e, 8'h78, 8'h56, 0);
    poll_evt(8'h04, 8'h01, 8'hb0, 8'h8f, 8'hbc, 8'h9a, 0);
    strobe(16'h1111, 16'h2222, 16'h3333);
    stall <= 1'b1;
    u_master.send(3'h3, station_addr, 8'h00, 8'h00, 8'h00, 2'h0, 1'b1);
    repeat (12) @(posedge clock);
    check("held", tx_valid, 1);
    check("refused", cmd_ready, 0);
    stall <= 1'b0;
    frame('{8'h04, 8'h81, 8'h01, station_addr, 8'hb0, 8'h8d, 8'h11,
            8'h11}, 0);
    ack(3'h0, station_addr, 8'h00, 8'h00, 8'h00);
    ack(3'h3, station_addr, 8'h00, 8'h00, 8'h00);
    $display("test fault done");
  endtask
  // Class 2 poll: saturated and mid-scale measurands
  task automatic t_meas;
    meas_hv <= 16'h0960;
    meas_lv <= 16'h04b0;
    u_master.send(3'h4, station_addr, 8'h00, 8'h00, 8'h00, 2'h0, 1'b1);
    frame('{8'h09, 8'h02, 8'h02, station_addr, 8'hb0, 8'h94, 8'hf9,
            8'h7f, 8'h00, 8'h40}, 0);
    $display("test measurand done");
  endtask
  // Verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Main sequence after the reset span
  initial begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    t_baud;
    t_link;
    t_cmd;
    t_events;
    t_gi;
    t_fault;
    t_meas;
    results;
  end
  // Watchdog, well beyond the few hundred cycles the tests need
  initial begin
    repeat (30000) @(posedge clock);
    n_mismatch++;
    results;
  end
endmodule // testbench
